// [pkg/pcd_defs.svh]
// command codes, defaults and field constants for the command default bank
`ifndef PCD_DEFS_SVH
`define PCD_DEFS_SVH
`define PCD_CMD_CHSEL 8'h00
`define PCD_CMD_RUN 8'h01
`define PCD_CMD_ENCFG 8'h02
`define PCD_CMD_FCLR 8'h03
`define PCD_CMD_PHSEL 8'h04
`define PCD_CMD_PGWR 8'h05
`define PCD_CMD_PGRD 8'h06
`define PCD_CMD_WLOCK 8'h10
`define PCD_CMD_SAVE 8'h15
`define PCD_CMD_RELOAD 8'h16
`define PCD_CMD_FEAT 8'h19
`define PCD_CMD_AMASK 8'h1b
`define PCD_CMD_VFMT 8'h20
`define PCD_CMD_VSET 8'h21
`define PCD_CMD_VADJ 8'h22
`define PCD_CMD_VCEIL 8'h24
`define PCD_CMD_VMHI 8'h25
`define PCD_CMD_VMLO 8'h26
`define PCD_CMD_SLEW 8'h27
`define PCD_CMD_DROOP 8'h28
`define PCD_CMD_SCALE 8'h29
`define PCD_CMD_VFLOOR 8'h2b
`define PCD_CMD_FSW 8'h33
`define PCD_CMD_PMODE 8'h34
`define PCD_CMD_VINON 8'h35
`define PCD_CMD_IGAIN 8'h38
`define PCD_CMD_IOFS 8'h39
`define PCD_CHSEL_ALL 8'hff
`define PCD_RST_RUN 8'h00
`define PCD_RST_ENCFG 8'h17
`define PCD_RST_PHSEL 8'hff
`define PCD_RST_WLOCK 8'h00
`define PCD_RST_FEAT 8'hd4
`define PCD_RST_VFMT 8'h16
`define PCD_RST_VSET_A 16'h0385
`define PCD_RST_VSET_B 16'h0333
`define PCD_RST_VCEIL_BOOT 16'h077a
`define PCD_RST_VCEIL_A 16'h04cd
`define PCD_RST_VCEIL_B 16'h059a
`define PCD_RST_SLEW 16'he050
`define PCD_RST_DROOP 16'hc800
`define PCD_RST_SCALE 16'he808
`define PCD_RST_FSW 16'h01f4
`define PCD_RST_PMODE 8'h03
`define PCD_RST_VINON 16'hf025
`define PCD_RST_IGAIN 16'hca80
`define PCD_RST_IOFS 16'he800
`define PCD_RST_MASK_IN 8'h08
`define PCD_RST_MASK_MFR 8'h06
`define PCD_RST_MASK_OTH 8'h00
`define PCD_GRP_INPUT 8'h7c
`define PCD_GRP_MFR 8'h80
`define PCD_GRP_OTHER 8'h7e
`endif

// [pkg/pcd_pkg.sv]
// types shared by the command default bank
package pcd_pkg;
    typedef enum logic [2:0] {
        PCD_IDLE = 3'b001,
        PCD_BUSY = 3'b010,
        PCD_DONE = 3'b100
    } pcd_state_t;
endpackage

// [src/pcd_bank.sv]
// per-channel command bank with link-clock command port
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defs.svh"

// What this block does
// - channel select resets to all channels
// - run control resets to zero
// - enable source config resets to 17h
// - fault clear pulses selected channel faults
// - phase select resets to all phases
// - paged write and read wrappers supported
// - write lock resets to all writable
// - save command copies settings to store
// - reload command restores settings from store
// - feature report reads fixed D4h
// - alert masks per group, input and vendor defaults
// - output voltage format reads 16h
// - setpoint defaults 0385h and 0333h
// - first channel ceiling default depends on boot strap, second channel fixed 059Ah
// - conduction policy resets to 03h
// - current offset resets to E800h
// - misc alert mask reads zero
module pcd_bank
    import pcd_pkg::*;
(
    // system side
    input wire logic clk,
    input wire logic reset_n,
    input wire logic first_channel_boot_strap,
    // command port, link clock domain
    input wire logic link_clk,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_group,
    input wire logic [7:0] cmd_page,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_done,
    output logic [15:0] cmd_rdata,
    // device side status
    output logic [1:0] fault_clear_pulse,
    output logic comms_fault,
    output logic nvm_busy,
    output logic [7:0] run_control_a,
    output logic [7:0] run_control_b,
    output logic [15:0] setpoint_a,
    output logic [15:0] setpoint_b
);
    localparam int NWORD = 18;
    // link side: capture request, toggle across
    logic lreq_tgl, lack_s1, lack_s2, lack_s3;
    logic [7:0] l_code, l_grp, l_page;
    logic [15:0] l_wdata;
    logic l_write, l_busy;
    logic ack_tgl;
    logic [15:0] rdata_hold;
    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lreq_tgl <= 1'b0;
            l_busy <= 1'b0;
            l_code <= 8'h00;
            l_grp <= 8'h00;
            l_page <= 8'h00;
            l_wdata <= 16'h0000;
            l_write <= 1'b0;
            cmd_done <= 1'b0;
            cmd_rdata <= 16'h0000;
        end
        else
        begin
            cmd_done <= 1'b0;
            if (cmd_valid && !l_busy && !cmd_done)
            begin
                l_code <= cmd_code;
                l_grp <= cmd_group;
                l_page <= cmd_page;
                l_wdata <= cmd_wdata;
                l_write <= cmd_write;
                lreq_tgl <= ~lreq_tgl;
                l_busy <= 1'b1;
            end
            else if (l_busy && (lack_s3 != lack_s2))
            begin
                l_busy <= 1'b0;
                cmd_done <= 1'b1;
                // hold register stable before ack toggles, safe to sample
                cmd_rdata <= rdata_hold;
            end
        end
    end
    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lack_s1 <= 1'b0;
            lack_s2 <= 1'b0;
            lack_s3 <= 1'b0;
        end
        else
        begin
            lack_s1 <= ack_tgl;
            lack_s2 <= lack_s1;
            lack_s3 <= lack_s2;
        end
    end
    // system side synchronisers
    logic req_s1, req_s2, req_s3, strap_s1, strap_s2;
    logic [1:0] boot_wait;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            boot_wait <= 2'b00;
        end
        else
        begin
            req_s1 <= lreq_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            strap_s1 <= first_channel_boot_strap;
            strap_s2 <= strap_s1;
            boot_wait <= {boot_wait[0], 1'b1};
        end
    end
    wire new_req = req_s2 != req_s3;
    // per-channel word table, index by command
    logic [15:0] op [2][NWORD];
    logic [15:0] nvm [2][NWORD];
    logic [7:0] chsel, wlock;
    logic [7:0] mask [2][7];
    logic strap_seen;
    pcd_state_t state;
    logic [4:0] nvm_cnt;
    logic nvm_save;

    function automatic logic [15:0] dflt(input int ch, input int i, input logic boot);
        logic [15:0] v;
        v = 16'h0000;
        unique case (i)
            0: v = {8'h00, `PCD_RST_RUN};
            1: v = {8'h00, `PCD_RST_ENCFG};
            2: v = {8'h00, `PCD_RST_PHSEL};
            3: v = {8'h00, `PCD_RST_VFMT};
            4: v = (ch == 0) ? `PCD_RST_VSET_A : `PCD_RST_VSET_B;
            6: v = (ch == 1) ? `PCD_RST_VCEIL_B :
                   (boot ? `PCD_RST_VCEIL_BOOT : `PCD_RST_VCEIL_A);
            9: v = `PCD_RST_SLEW;
            10: v = `PCD_RST_DROOP;
            11: v = `PCD_RST_SCALE;
            13: v = `PCD_RST_FSW;
            14: v = {8'h00, `PCD_RST_PMODE};
            15: v = `PCD_RST_VINON;
            16: v = `PCD_RST_IGAIN;
            17: v = `PCD_RST_IOFS;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction
    function automatic int widx(input logic [7:0] c);
        int r;
        r = -1;
        case (c)
            `PCD_CMD_RUN: r = 0;
            `PCD_CMD_ENCFG: r = 1;
            `PCD_CMD_PHSEL: r = 2;
            `PCD_CMD_VFMT: r = 3;
            `PCD_CMD_VSET: r = 4;
            `PCD_CMD_VADJ: r = 5;
            `PCD_CMD_VCEIL: r = 6;
            `PCD_CMD_VMHI: r = 7;
            `PCD_CMD_VMLO: r = 8;
            `PCD_CMD_SLEW: r = 9;
            `PCD_CMD_DROOP: r = 10;
            `PCD_CMD_SCALE: r = 11;
            `PCD_CMD_VFLOOR: r = 12;
            `PCD_CMD_FSW: r = 13;
            `PCD_CMD_PMODE: r = 14;
            `PCD_CMD_VINON: r = 15;
            `PCD_CMD_IGAIN: r = 16;
            `PCD_CMD_IOFS: r = 17;
            default: r = -1;
        endcase
        return r;
    endfunction

    function automatic int gidx(input logic [7:0] g);
        // group index within the mask set; 0..5 writable groups, 6 misc
        int r;
        r = (g == `PCD_GRP_INPUT) ? 3 : (g == `PCD_GRP_MFR) ? 5 :
            (g == `PCD_GRP_OTHER) ? 6 : (g == 8'h7a) ? 1 : (g == 8'h7b) ? 2 :
            (g == 8'h7d) ? 4 : 0;
        return r;
    endfunction

    // wrapped commands take the page from the request itself
    wire wrapped = (l_code == `PCD_CMD_PGWR) || (l_code == `PCD_CMD_PGRD);
    wire [7:0] eff_page = wrapped ? l_page : chsel;
    wire [7:0] eff_code = wrapped ? l_grp : l_code;
    wire bad_dir = (l_code == `PCD_CMD_PGWR && !l_write) || (l_code == `PCD_CMD_PGRD && l_write) ||
        (!l_write && (eff_code == `PCD_CMD_FCLR || eff_code == `PCD_CMD_SAVE ||
        eff_code == `PCD_CMD_RELOAD)) ||
        (l_write && eff_code == `PCD_CMD_FEAT) ||
        (l_write && eff_code == `PCD_CMD_AMASK && gidx(l_wdata[15:8]) == 6);
    wire hit_a = (eff_page != 8'h01);
    wire hit_b = (eff_page != 8'h00);
    wire locked = (wlock != `PCD_RST_WLOCK) && (eff_code != `PCD_CMD_WLOCK) &&
        (eff_code != `PCD_CMD_CHSEL);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            chsel <= `PCD_CHSEL_ALL;
            wlock <= `PCD_RST_WLOCK;
            ack_tgl <= 1'b0;
            rdata_hold <= 16'h0000;
            comms_fault <= 1'b0;
            fault_clear_pulse <= 2'b00;
            state <= PCD_IDLE;
            nvm_cnt <= 5'd0;
            nvm_save <= 1'b0;
            nvm_busy <= 1'b0;
            strap_seen <= 1'b0;
            for (int c = 0; c < 2; c++)
            begin
                for (int i = 0; i < NWORD; i++)
                begin
                    op[c][i] <= 16'h0000;
                    nvm[c][i] <= 16'h0000;
                end
                for (int g = 0; g < 7; g++)
                    mask[c][g] <= 8'h00;
            end
        end
        else
        begin
            fault_clear_pulse <= 2'b00;
            // load defaults once strap is synchronised after release
            if (!strap_seen && boot_wait[1])
            begin
                strap_seen <= 1'b1;
                for (int c = 0; c < 2; c++)
                begin
                    for (int i = 0; i < NWORD; i++)
                    begin
                        op[c][i] <= dflt(c, i, strap_s2);
                        nvm[c][i] <= dflt(c, i, 1'b0);
                    end
                    mask[c][3] <= `PCD_RST_MASK_IN;
                    mask[c][5] <= `PCD_RST_MASK_MFR;
                    mask[c][6] <= `PCD_RST_MASK_OTH;
                end
            end
            unique case (state)
                PCD_IDLE:
                begin
                    if (new_req)
                    begin
                        state <= PCD_DONE;
                        rdata_hold <= 16'h0000;
                        if (bad_dir)
                            comms_fault <= 1'b1;
                        else if (!l_write)
                        begin
                            if (eff_code == `PCD_CMD_CHSEL)
                                rdata_hold <= {8'h00, chsel};
                            else if (eff_code == `PCD_CMD_WLOCK)
                                rdata_hold <= {8'h00, wlock};
                            else if (eff_code == `PCD_CMD_FEAT)
                                rdata_hold <= {8'h00, `PCD_RST_FEAT};
                            else if (eff_code == `PCD_CMD_AMASK)
                                rdata_hold <= {8'h00, mask[hit_a ? 0 : 1][gidx(l_wdata[15:8])]};
                            else if (widx(eff_code) >= 0)
                                rdata_hold <= op[hit_a ? 0 : 1][widx(eff_code)];
                            else
                                comms_fault <= 1'b1;
                        end
                        else if (eff_code == `PCD_CMD_CHSEL)
                            chsel <= l_wdata[7:0];
                        else if (eff_code == `PCD_CMD_WLOCK)
                            wlock <= l_wdata[7:0];
                        else if (eff_code == `PCD_CMD_FCLR)
                        begin
                            fault_clear_pulse <= {hit_b, hit_a};
                            comms_fault <= 1'b0;
                        end
                        else if (locked)
                            comms_fault <= 1'b1;
                        else if (eff_code == `PCD_CMD_SAVE || eff_code == `PCD_CMD_RELOAD)
                        begin
                            state <= PCD_BUSY;
                            nvm_save <= (eff_code == `PCD_CMD_SAVE);
                            nvm_cnt <= 5'd0;
                            nvm_busy <= 1'b1;
                        end
                        else if (eff_code == `PCD_CMD_AMASK)
                        begin
                            if (hit_a)
                                mask[0][gidx(l_wdata[15:8])] <= l_wdata[7:0];
                            if (hit_b)
                                mask[1][gidx(l_wdata[15:8])] <= l_wdata[7:0];
                        end
                        else if (widx(eff_code) >= 0 && eff_code != `PCD_CMD_VFMT)
                        begin
                            // format is fixed, so writes to it are accepted and dropped
                            if (hit_a)
                                op[0][widx(eff_code)] <= l_wdata;
                            if (hit_b)
                                op[1][widx(eff_code)] <= l_wdata;
                        end
                        else if (widx(eff_code) < 0)
                            comms_fault <= 1'b1;
                    end
                end
                PCD_BUSY:
                begin
                    // one word per channel per cycle
                    for (int c = 0; c < 2; c++)
                    begin
                        if (nvm_save)
                            nvm[c][nvm_cnt] <= op[c][nvm_cnt];
                        else
                            op[c][nvm_cnt] <= nvm[c][nvm_cnt];
                    end
                    nvm_cnt <= nvm_cnt + 5'd1;
                    if (nvm_cnt == 5'(NWORD - 1))
                    begin
                        state <= PCD_DONE;
                        nvm_busy <= 1'b0;
                    end
                end
                PCD_DONE:
                begin
                    ack_tgl <= ~ack_tgl;
                    state <= PCD_IDLE;
                end
                default: state <= PCD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_control_a <= `PCD_RST_RUN;
            run_control_b <= `PCD_RST_RUN;
            setpoint_a <= `PCD_RST_VSET_A;
            setpoint_b <= `PCD_RST_VSET_B;
        end
        else
        begin
            run_control_a <= op[0][0][7:0];
            run_control_b <= op[1][0][7:0];
            setpoint_a <= strap_seen ? op[0][4] : `PCD_RST_VSET_A;
            setpoint_b <= strap_seen ? op[1][4] : `PCD_RST_VSET_B;
        end
    end

    a_chsel_reset: assert property (@(posedge clk) $rose(reset_n) |-> chsel == `PCD_CHSEL_ALL)
        else $error("channel select not all after reset");
    a_feat_fixed: assert property (@(posedge clk) disable iff (!reset_n)
        (state == PCD_DONE && !l_write && eff_code == `PCD_CMD_FEAT && !bad_dir)
        |-> rdata_hold == 16'h00d4)
        else $error("feature report wrong");
    a_nvm_length: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(nvm_busy) |-> nvm_busy [*8] ##10 nvm_busy ##1 !nvm_busy)
        else $error("store walk length wrong");
    a_clear_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        fault_clear_pulse != 2'b00 |=> fault_clear_pulse == 2'b00)
        else $error("fault clear not a pulse");
    a_misc_mask: assert property (@(posedge clk) disable iff (!reset_n)
        mask[0][6] == 8'h00 && mask[1][6] == 8'h00)
        else $error("misc mask changed");
    a_dir_fault: assert property (@(posedge clk) disable iff (!reset_n)
        (state == PCD_IDLE && new_req && bad_dir) |=> comms_fault)
        else $error("bad direction not flagged");
    a_done_link: assert property (@(posedge link_clk) disable iff (!reset_n)
        cmd_done |=> !cmd_done)
        else $error("done held too long");
    a_fmt_fixed: assert property (@(posedge clk) disable iff (!reset_n)
        strap_seen |-> op[0][3] == 16'h0016 && op[1][3] == 16'h0016)
        else $error("format word changed");
    c_save: cover property (@(posedge clk) $rose(nvm_busy) && nvm_save);
    c_reload: cover property (@(posedge clk) $rose(nvm_busy) && !nvm_save);
    c_clear: cover property (@(posedge clk) fault_clear_pulse == 2'b11);
    c_fault: cover property (@(posedge clk) $rose(comms_fault));
endmodule // pcd_bank
`default_nettype wire

// [sim/pcd_host_model.sv]
// host model driving the command port on the link clock
`timescale 1ns/100ps
`default_nettype none
module pcd_host_model
    import pcd_pkg::*;
(
    // link clock and request
    input wire logic link_clk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_group,
    output logic [7:0] cmd_page,
    output logic [15:0] cmd_wdata,
    // answer
    input wire logic cmd_done,
    input wire logic [15:0] cmd_rdata
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_group = 8'h00;
        cmd_page = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // one request, held until done is seen at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] grp,
                        input logic [7:0] page, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok);
        int n;
        ok = 1'b0;
        rd = 16'h0000;
        @(posedge link_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        cmd_group = grp;
        cmd_page = page;
        cmd_wdata = wd;
        for (n = 0; n < 400 && !ok; n++)
        begin
            @(posedge link_clk);
            if (cmd_done === 1'b1)
            begin
                ok = 1'b1;
                rd = cmd_rdata;
            end
        end
        #1;
        cmd_valid = 1'b0;
        // released fields show garbage, not the last value
        cmd_write = ~cmd_write;
        cmd_code = ~cmd_code;
        cmd_group = ~cmd_group;
        cmd_page = ~cmd_page;
        cmd_wdata = ~cmd_wdata;
    endtask
endmodule // pcd_host_model
`default_nettype wire

// [sim/test_pcd_bank.sv]
// self-checking bench for the command default bank
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defs.svh"
module test_pcd_bank
    import pcd_pkg::*;
;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic strap = 1'b1;
    logic cmd_valid, cmd_write, cmd_done, comms_fault, nvm_busy;
    logic [7:0] cmd_code, cmd_group, cmd_page, run_a, run_b;
    logic [15:0] cmd_wdata, cmd_rdata, set_a, set_b;
    logic [1:0] fc_pulse;
    logic [1:0] fc_seen = 2'b00;
    logic busy_seen = 1'b0;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] codes [15] = '{`PCD_CMD_RUN, `PCD_CMD_ENCFG, `PCD_CMD_PHSEL, `PCD_CMD_PMODE,
        `PCD_CMD_VFMT, `PCD_CMD_VADJ, `PCD_CMD_VMHI, `PCD_CMD_VMLO, `PCD_CMD_SLEW,
        `PCD_CMD_DROOP, `PCD_CMD_SCALE, `PCD_CMD_VFLOOR, `PCD_CMD_FSW, `PCD_CMD_IGAIN,
        `PCD_CMD_IOFS};
    logic [15:0] dflt [15] = '{16'h0000, 16'h0017, 16'h00ff, 16'h0003, 16'h0016, 16'h0000,
        16'h0000, 16'h0000, 16'he050, 16'hc800, 16'he808, 16'h0000, 16'h01f4, 16'hca80,
        16'he800};

    always #50 clk = ~clk;
    always #6 link_clk = ~link_clk;

    pcd_bank u_dut (.clk(clk), .reset_n(reset_n), .first_channel_boot_strap(strap),
        .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_group(cmd_group), .cmd_page(cmd_page),
        .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .cmd_rdata(cmd_rdata),
        .fault_clear_pulse(fc_pulse), .comms_fault(comms_fault), .nvm_busy(nvm_busy),
        .run_control_a(run_a), .run_control_b(run_b), .setpoint_a(set_a),
        .setpoint_b(set_b));

    pcd_host_model u_host (.link_clk(link_clk), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_group(cmd_group),
        .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .cmd_done(cmd_done),
        .cmd_rdata(cmd_rdata));

    // pulses are too short to poll from the tasks
    always @(posedge clk)
    begin
        fc_seen <= fc_seen | fc_pulse;
        busy_seen <= busy_seen | nvm_busy;
    end

    task automatic give_verdict();
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // paged accesses go through the wrapper codes with the target in cmd_group
    task automatic xact(input logic w, input logic paged, input logic [7:0] code,
                        input logic [7:0] pg, input logic [15:0] wd, output logic [15:0] rd);
        logic ok;
        if (paged)
            u_host.xfer(w, w ? `PCD_CMD_PGWR : `PCD_CMD_PGRD, code, pg, wd, rd, ok);
        else
            u_host.xfer(w, code, 8'h00, 8'h00, wd, rd, ok);
        check({15'h0000, ok}, 16'h0001);
    endtask

    task automatic wr(input logic paged, input logic [7:0] code, input logic [7:0] pg,
                      input logic [15:0] wd);
        logic [15:0] rd;
        xact(1'b1, paged, code, pg, wd, rd);
    endtask

    task automatic rd(input logic paged, input logic [7:0] code, input logic [7:0] pg,
                      input logic [7:0] grp, input logic [15:0] exp);
        logic [15:0] v;
        xact(1'b0, paged, code, pg, {grp, 8'h00}, v);
        check(v, exp);
    endtask

    task automatic do_reset(input logic boot);
        #1;
        reset_n = 1'b0;
        strap = boot;
        repeat (4) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (6) @(posedge clk);
    endtask

    initial
    begin
        do_reset(1'b1);
        check(set_a, 16'h0385);
        check(set_b, 16'h0333);
        check({run_a, run_b}, 16'h0000);
        rd(1'b0, `PCD_CMD_CHSEL, 8'h00, 8'h00, 16'h00ff);
        for (int i = 0; i < 15; i++)
            for (int p = 0; p < 2; p++)
                rd(1'b1, codes[i], 8'(p), 8'h00, dflt[i]);
        rd(1'b1, `PCD_CMD_VSET, 8'h00, 8'h00, 16'h0385);
        rd(1'b1, `PCD_CMD_VSET, 8'h01, 8'h00, 16'h0333);
        rd(1'b1, `PCD_CMD_VCEIL, 8'h00, 8'h00, 16'h077a);
        rd(1'b1, `PCD_CMD_VCEIL, 8'h01, 8'h00, 16'h059a);
        rd(1'b0, `PCD_CMD_WLOCK, 8'h00, 8'h00, 16'h0000);
        rd(1'b0, `PCD_CMD_FEAT, 8'h00, 8'h00, 16'h00d4);
        rd(1'b1, `PCD_CMD_AMASK, 8'h00, `PCD_GRP_INPUT, 16'h0008);
        rd(1'b1, `PCD_CMD_AMASK, 8'h01, `PCD_GRP_MFR, 16'h0006);
        rd(1'b1, `PCD_CMD_AMASK, 8'h00, 8'h7a, 16'h0000);
        rd(1'b0, `PCD_CMD_AMASK, 8'h00, `PCD_GRP_OTHER, 16'h0000);
        // strap low on a fresh reset gives the stored ceiling
        do_reset(1'b0);
        rd(1'b1, `PCD_CMD_VCEIL, 8'h00, 8'h00, 16'h04cd);
        wr(1'b0, `PCD_CMD_VFMT, 8'h00, 16'h0055);
        rd(1'b1, `PCD_CMD_VFMT, 8'h01, 8'h00, 16'h0016);
        wr(1'b1, `PCD_CMD_AMASK, 8'h00, 16'h7a55);
        rd(1'b1, `PCD_CMD_AMASK, 8'h00, 8'h7a, 16'h0055);
        rd(1'b1, `PCD_CMD_AMASK, 8'h01, 8'h7a, 16'h0000);
        check({15'h0000, comms_fault}, 16'h0000);
        wr(1'b1, `PCD_CMD_VSET, 8'h00, 16'h0412);
        check(set_a, 16'h0412);
        check(set_b, 16'h0333);
        rd(1'b1, `PCD_CMD_VSET, 8'h01, 8'h00, 16'h0333);
        wr(1'b1, `PCD_CMD_RUN, 8'h01, 16'h0080);
        check({run_a, run_b}, 16'h0080);
        fc_seen = 2'b00;
        wr(1'b0, `PCD_CMD_FCLR, 8'h00, 16'h0000);
        check({14'h0000, fc_seen}, 16'h0003);
        wr(1'b0, `PCD_CMD_CHSEL, 8'h00, 16'h0001);
        fc_seen = 2'b00;
        wr(1'b0, `PCD_CMD_FCLR, 8'h00, 16'h0000);
        check({14'h0000, fc_seen}, 16'h0002);
        rd(1'b0, `PCD_CMD_FCLR, 8'h00, 8'h00, 16'h0000);
        check({15'h0000, comms_fault}, 16'h0001);
        wr(1'b0, `PCD_CMD_FCLR, 8'h00, 16'h0000);
        check({15'h0000, comms_fault}, 16'h0000);
        wr(1'b0, `PCD_CMD_FEAT, 8'h00, 16'h0055);
        check({15'h0000, comms_fault}, 16'h0001);
        rd(1'b0, `PCD_CMD_FEAT, 8'h00, 8'h00, 16'h00d4);
        wr(1'b0, `PCD_CMD_FCLR, 8'h00, 16'h0000);
        wr(1'b0, `PCD_CMD_WLOCK, 8'h00, 16'h0080);
        wr(1'b0, `PCD_CMD_PMODE, 8'h00, 16'h0000);
        check({15'h0000, comms_fault}, 16'h0001);
        wr(1'b0, `PCD_CMD_WLOCK, 8'h00, 16'h0000);
        rd(1'b1, `PCD_CMD_PMODE, 8'h01, 8'h00, 16'h0003);
        wr(1'b0, `PCD_CMD_FCLR, 8'h00, 16'h0000);
        wr(1'b0, `PCD_CMD_CHSEL, 8'h00, 16'h0000);
        wr(1'b0, `PCD_CMD_VSET, 8'h00, 16'h0400);
        busy_seen = 1'b0;
        wr(1'b0, `PCD_CMD_SAVE, 8'h00, 16'h0000);
        check({15'h0000, busy_seen}, 16'h0001);
        wr(1'b0, `PCD_CMD_VSET, 8'h00, 16'h0500);
        check(set_a, 16'h0500);
        wr(1'b0, `PCD_CMD_RELOAD, 8'h00, 16'h0000);
        rd(1'b0, `PCD_CMD_VSET, 8'h00, 8'h00, 16'h0400);
        check(set_a, 16'h0400);
        give_verdict();
    end
endmodule // test_pcd_bank
`default_nettype wire
